/* File: src/rcs_pkg.sv */
// Package of the receive output clock select block: three-level select codes,
// decode helpers, mode numbers and cycle counts shared by both ends.
// Assumes a single 25 MHz core clock at each end.
package rcs_pkg;

    typedef enum logic [1:0] {TERN_LOW, TERN_MID, TERN_HIGH} rcs_tern_t;

    // Codes of a three-level pin as carried on the link; CODE_FLOAT is an open pin
    localparam logic [1:0] CODE_LOW = 2'h0;
    localparam logic [1:0] CODE_MID = 2'h1;
    localparam logic [1:0] CODE_HIGH = 2'h2;
    localparam logic [1:0] CODE_FLOAT = 2'h3;

    // Receive mode numbers that use dual-channel bonding
    localparam logic [3:0] MODE_DUAL_1 = 4'h3;
    localparam logic [3:0] MODE_DUAL_2 = 4'h5;

    localparam int REF_CHAR_CYCLES = 8;   // core cycles per reference character
    localparam int TX_CHAR_CYCLES = 8;    // core cycles per transmit character
    localparam int CLK_HIGH_CYCLES = 4;   // high time of a full-rate character clock
    localparam int CAPTURE_DELAY = 2;     // host waits this long after a seen edge
    localparam int SETTLE_CYCLES = 16;    // outputs held after a select change
    localparam logic [7:0] MASTER_MAP_DEFAULT = 8'he4;

    function automatic rcs_tern_t tern_decode(input logic [1:0] code);
        // An open pin biases itself to the middle level
        return (code == CODE_LOW) ? TERN_LOW : (code == CODE_HIGH) ? TERN_HIGH : TERN_MID;
    endfunction

    // Two three-level selects give mode 0..8
    function automatic logic [3:0] mode_decode(input logic [3:0] code);
        return 4'(3 * int'(tern_decode(code[3:2])) + int'(tern_decode(code[1:0])));
    endfunction

endpackage

/* File: src/rcs_if.sv */
// Pins between the transceiver receive output block and host logic.
// Resolves the shared receive clock pins and the three-state parity pins;
// an undriven pin reads low.
`timescale 1ns/1ns
`default_nettype none
interface rcs_if;
    logic [1:0] rx_clk_src;
    logic [1:0] frame_char;
    logic [1:0] dec_table;
    logic [1:0] parity_ctl;
    logic [3:0] rx_mode;
    logic [3:0] tx_mode;
    logic [3:0] tx_in_clk;
    logic rx_rate;
    logic reframe_en;
    logic tx_phase_rst;
    logic [31:0] rx_data;
    logic [11:0] rx_status;
    logic [3:0] rx_parity_drv;
    logic [3:0] rx_parity_oe;
    logic [3:0] rx_clk_t_drv;
    logic [3:0] rx_clk_c_drv;
    logic [3:0] rx_clk_oe;
    logic [3:0] sel_drv;
    logic [3:0] sel_oe;
    logic [3:0] rx_clk_t;
    logic [3:0] rx_clk_c;
    logic [3:0] rx_parity;

    assign rx_clk_t = (rx_clk_oe & rx_clk_t_drv) | (~rx_clk_oe & sel_oe & sel_drv);
    assign rx_clk_c = rx_clk_oe & rx_clk_c_drv;
    assign rx_parity = rx_parity_oe & rx_parity_drv;

    modport dev (
        input rx_clk_src, frame_char, dec_table, parity_ctl, rx_mode, tx_mode,
        input tx_in_clk, rx_rate, reframe_en, tx_phase_rst, rx_clk_t,
        output rx_data, rx_status, rx_parity_drv, rx_parity_oe,
        output rx_clk_t_drv, rx_clk_c_drv, rx_clk_oe
    );
    modport host (
        output rx_clk_src, frame_char, dec_table, parity_ctl, rx_mode, tx_mode,
        output tx_in_clk, rx_rate, reframe_en, tx_phase_rst, sel_drv, sel_oe,
        input rx_data, rx_status, rx_parity, rx_clk_t, rx_clk_c
    );
endinterface
`default_nettype wire

/* File: src/rcs_sync.sv */
// Three-stage synchroniser for pins from outside the core clock domain.
// A bit changes once the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module rcs_sync #(
    parameter int W = 1
) (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Async reset, active high
    input wire logic [W-1:0] d_i, // Raw pin levels
    output logic [W-1:0] q_o // Filtered levels
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q_o <= '0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            q_o <= (s3 & ~(s2 ^ s3)) | (q_o & (s2 ^ s3));
        end
    end
endmodule // rcs_sync
`default_nettype wire

/* File: src/rcs_device.sv */
// Transceiver end: receive output register, receive clock selection, parity,
// framer and decoder controls, transmit input clock phase capture.
// Assumes recovered character strobes and characters arrive on the core clock.
`timescale 1ns/1ns
`default_nettype none
module rcs_device
    import rcs_pkg::*;
#(
    parameter logic [7:0] MASTER_MAP = MASTER_MAP_DEFAULT
) (
    input wire logic CORE_CLK_I, // Core clock, 25 MHz
    input wire logic SYS_RST_I, // Async reset, active high
    rcs_if.dev LINK, // Pins toward host logic
    input wire logic [3:0] REC_CHAR_I, // Recovered character strobe per channel
    input wire logic [39:0] RAW_CHAR_I, // Raw 10-bit characters, channel A lowest
    input wire logic [31:0] DEC_BYTE_I, // Decoded bytes
    input wire logic [11:0] DEC_STATUS_I, // Received character status codes
    input wire logic [3:0] COMMA_I, // Raw character is a comma
    output logic DEC_ENABLE_O, // Decoder in use
    output logic DEC_ALT_TABLE_O, // Alternate special code table
    output logic FRAME_COMMA_O, // Framer matches comma, both disparities
    output logic FRAME_K285_O, // Framer matches K28.5, both disparities
    output logic FRAME_TEST_O, // Framing test selection
    output logic REFRAME_O, // Framers may realign
    output logic [3:0] RX_MODE_O, // Receive mode 0..8
    output logic [3:0] TX_MODE_O, // Transmit mode 0..8
    output logic [11:0] TX_PHASE_O, // Captured phase per transmit input clock
    output logic RECONFIG_O // Outputs held while selects settle
);
    localparam int SW = 25;

    logic [SW-1:0] pin_raw;
    logic [SW-1:0] pin;
    rcs_tern_t src;
    rcs_tern_t frm;
    rcs_tern_t dec;
    rcs_tern_t par;
    logic [3:0] rxm;
    logic [3:0] txm;
    logic rate;
    logic sel_b;
    logic sel_d;
    logic half;
    logic dual;
    logic [1:0] master;
    logic [8:0] watch;
    logic [8:0] watch_prev;
    logic [4:0] settle;
    logic [2:0] ref_div;
    logic [4:0] gen_str;
    logic [4:0] gen_lvl;
    logic [4:0][2:0] gen_cnt;
    logic ref_dly;
    logic [3:0] next_clk;
    logic [3:0] next_oe;
    logic [3:0] grp;
    logic [3:0] grp_prev;
    logic [3:0] launch;
    logic [31:0] next_data;
    logic [11:0] next_st;
    logic [3:0] next_par;
    logic [2:0] tx_div;
    logic [3:0] tx_clk_prev;

    assign pin_raw = {LINK.rx_clk_src, LINK.rx_mode, LINK.tx_mode, LINK.frame_char,
        LINK.dec_table, LINK.parity_ctl, LINK.rx_rate, LINK.reframe_en,
        LINK.tx_phase_rst, LINK.tx_in_clk, LINK.rx_clk_t[3], LINK.rx_clk_t[1]};

    rcs_sync #(
        .W(SW)
    ) u_pin_sync (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .d_i(pin_raw),
        .q_o(pin)
    );

    assign src = tern_decode(pin[24:23]);
    assign rxm = mode_decode(pin[22:19]);
    assign txm = mode_decode(pin[18:15]);
    assign frm = tern_decode(pin[14:13]);
    assign dec = tern_decode(pin[12:11]);
    assign par = tern_decode(pin[10:9]);
    assign rate = pin[8];
    // The B and D true pins only mean something while this end leaves them undriven
    assign sel_d = pin[1];
    assign sel_b = pin[0];
    // Reference clocking is always full rate; rate is ignored here while the source select is low
    assign half = rate && (src != TERN_LOW);
    assign dual = (rxm == MODE_DUAL_1) || (rxm == MODE_DUAL_2);
    assign master = MASTER_MAP[{sel_b, sel_d, 1'b0} +: 2];
    assign watch = {pin[24:19], pin[12:11], rate};
    assign gen_str = {ref_div == 3'(REF_CHAR_CYCLES - 1), REC_CHAR_I};

    // Any change of clock source, receive mode, decoder or rate selects restarts the recovered clocks and holds the outputs
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            watch_prev <= '0;
            settle <= 5'(SETTLE_CYCLES);
            RECONFIG_O <= 1'b1;
        end else begin
            watch_prev <= watch;
            if (watch != watch_prev) begin
                settle <= 5'(SETTLE_CYCLES);
                RECONFIG_O <= 1'b1;
            end else if (settle != 5'h0) begin
                settle <= settle - 5'h1;
                RECONFIG_O <= (settle != 5'h1);
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ref_div <= '0;
        end else if (ref_div == 3'(REF_CHAR_CYCLES - 1)) begin
            ref_div <= '0;
        end else begin
            ref_div <= ref_div + 3'h1;
        end
    end

    // Character clocks: four recovered ones, the fifth follows the reference
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            gen_lvl <= '0;
            gen_cnt <= '0;
        end else begin
            for (int g = 0; g < 5; g++) begin
                if (RECONFIG_O && g < 4) begin
                    gen_lvl[g] <= 1'b0;
                    gen_cnt[g] <= '0;
                end else if (gen_str[g]) begin
                    gen_lvl[g] <= (half && g < 4) ? ~gen_lvl[g] : 1'b1;
                    gen_cnt[g] <= 3'(CLK_HIGH_CYCLES - 1);
                end else if (gen_cnt[g] != 3'h0) begin
                    gen_cnt[g] <= gen_cnt[g] - 3'h1;
                end else if (!(half && g < 4)) begin
                    gen_lvl[g] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        next_clk = gen_lvl[3:0];
        next_oe = 4'hf;
        unique case (src)
            TERN_LOW: begin
                // C lags A by one core cycle so the host can pick its timing
                next_clk = {1'b0, ref_dly, 1'b0, gen_lvl[4]};
                next_oe = 4'h5;
            end
            TERN_MID: begin
                next_oe = 4'hf;
            end
            TERN_HIGH: begin
                next_oe = 4'h5;
                if (dual) begin
                    next_clk = {1'b0, sel_d ? gen_lvl[3] : gen_lvl[2],
                        1'b0, sel_b ? gen_lvl[1] : gen_lvl[0]};
                end else begin
                    next_clk = {1'b0, gen_lvl[master], 1'b0, gen_lvl[master]};
                end
            end
            default: begin
                next_oe = 4'hf;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ref_dly <= 1'b0;
            LINK.rx_clk_t_drv <= '0;
            LINK.rx_clk_c_drv <= '1;
            LINK.rx_clk_oe <= '0;
        end else begin
            ref_dly <= gen_lvl[4];
            LINK.rx_clk_t_drv <= next_clk;
            LINK.rx_clk_c_drv <= ~next_clk;
            LINK.rx_clk_oe <= next_oe;
        end
    end

    // Each channel's output register follows the clock pin that serves its group
    always_comb begin
        for (int ch = 0; ch < 4; ch++) begin
            grp[ch] = (src == TERN_MID) ? LINK.rx_clk_t_drv[ch]
                : LINK.rx_clk_t_drv[{ch[1], 1'b0}];
        end
    end
    // Half rate launches on the complement's rising edge as well
    assign launch = (grp & ~grp_prev) | ({4{half}} & ~grp & grp_prev);

    always_comb begin
        for (int ch = 0; ch < 4; ch++) begin
            if (dec == TERN_LOW) begin
                next_data[ch*8 +: 8] = RAW_CHAR_I[ch*10+2 +: 8];
                next_st[ch*3 +: 3] = {COMMA_I[ch], RAW_CHAR_I[ch*10 +: 2]};
            end else begin
                next_data[ch*8 +: 8] = DEC_BYTE_I[ch*8 +: 8];
                next_st[ch*3 +: 3] = DEC_STATUS_I[ch*3 +: 3];
            end
            if (par == TERN_HIGH) begin
                next_par[ch] = ~^{next_data[ch*8 +: 8], next_st[ch*3 +: 3]};
            end else if (dec == TERN_LOW) begin
                next_par[ch] = ~^{next_data[ch*8 +: 8], next_st[ch*3 +: 2]};
            end else begin
                next_par[ch] = ~^next_data[ch*8 +: 8];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            grp_prev <= '0;
            LINK.rx_data <= '0;
            LINK.rx_status <= '0;
            LINK.rx_parity_drv <= '0;
            LINK.rx_parity_oe <= '0;
        end else begin
            grp_prev <= grp;
            LINK.rx_parity_oe <= {4{par != TERN_LOW}};
            for (int ch = 0; ch < 4; ch++) begin
                if (launch[ch] && !RECONFIG_O) begin
                    LINK.rx_data[ch*8 +: 8] <= next_data[ch*8 +: 8];
                    LINK.rx_status[ch*3 +: 3] <= next_st[ch*3 +: 3];
                    LINK.rx_parity_drv[ch] <= next_par[ch];
                end
            end
        end
    end

    // Internal transmit character phase; input clock edges sample it while unlocked
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            tx_div <= '0;
            tx_clk_prev <= '0;
            TX_PHASE_O <= '0;
        end else begin
            tx_div <= (tx_div == 3'(TX_CHAR_CYCLES - 1)) ? 3'h0 : tx_div + 3'h1;
            tx_clk_prev <= pin[5:2];
            for (int i = 0; i < 4; i++) begin
                if (pin[2+i] && !tx_clk_prev[i] && !pin[6]) begin
                    TX_PHASE_O[i*3 +: 3] <= tx_div;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            DEC_ENABLE_O <= 1'b0;
            DEC_ALT_TABLE_O <= 1'b0;
            FRAME_COMMA_O <= 1'b0;
            FRAME_K285_O <= 1'b0;
            FRAME_TEST_O <= 1'b0;
            REFRAME_O <= 1'b0;
            RX_MODE_O <= '0;
            TX_MODE_O <= '0;
        end else begin
            DEC_ENABLE_O <= (dec != TERN_LOW);
            DEC_ALT_TABLE_O <= (dec == TERN_HIGH);
            FRAME_COMMA_O <= (frm == TERN_MID);
            FRAME_K285_O <= (frm == TERN_HIGH);
            FRAME_TEST_O <= (frm == TERN_LOW);
            REFRAME_O <= pin[7];
            RX_MODE_O <= rxm;
            TX_MODE_O <= txm;
        end
    end
endmodule // rcs_device
`default_nettype wire

/* File: src/rcs_host.sv */
// Host end: drives the static selects and transmit input clocks, samples the
// receive clocks and latches each channel's character.
// Assumes the device end of the same interface on the far side.
`timescale 1ns/1ns
`default_nettype none
module rcs_host
    import rcs_pkg::*;
(
    input wire logic CORE_CLK_I, // Core clock, 25 MHz
    input wire logic SYS_RST_I, // Async reset, active high
    rcs_if.host LINK, // Pins toward the device
    input wire logic [1:0] RX_CLK_SRC_I, // Receive clock source code
    input wire logic [3:0] RX_MODE_I, // Receive mode codes
    input wire logic [3:0] TX_MODE_I, // Transmit mode codes
    input wire logic [1:0] FRAME_CHAR_I, // Framing character code
    input wire logic [1:0] DEC_TABLE_I, // Decoder select code
    input wire logic [1:0] PARITY_CTL_I, // Parity control code
    input wire logic RX_RATE_I, // Half-rate receive clocks wanted
    input wire logic REFRAME_I, // Allow reframing
    input wire logic TX_PHASE_RST_N_I, // Transmit phase align reset, low adjusts
    input wire logic MULTI_DEVICE_I, // Bonded across devices
    input wire logic [1:0] MASTER_SEL_I, // Master select levels, bit0 B, bit1 D
    output logic [31:0] RX_DATA_O, // Latched characters
    output logic [11:0] RX_STATUS_O, // Latched status bits
    output logic [3:0] RX_PARITY_O, // Latched parity bits
    output logic [3:0] RX_VALID_O // One-cycle pulse per latched character
);
    localparam int RW = 56;

    rcs_tern_t src;
    logic [1:0] src_code;
    logic [RW-1:0] rx_raw;
    logic [RW-1:0] rx;
    logic [3:0] t;
    logic [3:0] c;
    logic [3:0] t_prev;
    logic [3:0] c_prev;
    logic [3:0] grp_t;
    logic [3:0] grp_c;
    logic [3:0] grp_t_prev;
    logic [3:0] grp_c_prev;
    logic [3:0] edge_seen;
    logic [3:0][CAPTURE_DELAY-1:0] cap;
    logic [2:0] tx_div;
    logic half;

    // Cross-device bonding needs reference clocking
    assign src_code = MULTI_DEVICE_I ? CODE_LOW : RX_CLK_SRC_I;
    assign src = tern_decode(src_code);

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            LINK.rx_clk_src <= CODE_MID;
            LINK.rx_mode <= '0;
            LINK.tx_mode <= '0;
            LINK.frame_char <= CODE_MID;
            LINK.dec_table <= CODE_MID;
            LINK.parity_ctl <= CODE_LOW;
            LINK.rx_rate <= 1'b0;
            LINK.reframe_en <= 1'b0;
            LINK.tx_phase_rst <= 1'b0;
            LINK.sel_drv <= '0;
            LINK.sel_oe <= '0;
            half <= 1'b0;
        end else begin
            LINK.rx_clk_src <= src_code;
            LINK.rx_mode <= RX_MODE_I;
            LINK.tx_mode <= TX_MODE_I;
            LINK.frame_char <= FRAME_CHAR_I;
            LINK.dec_table <= DEC_TABLE_I;
            LINK.parity_ctl <= PARITY_CTL_I;
            LINK.rx_rate <= RX_RATE_I && (src != TERN_LOW);
            half <= RX_RATE_I && (src != TERN_LOW);
            LINK.reframe_en <= REFRAME_I;
            LINK.tx_phase_rst <= TX_PHASE_RST_N_I;
            LINK.sel_drv <= {MASTER_SEL_I[1], 1'b0, MASTER_SEL_I[0], 1'b0};
            LINK.sel_oe <= (src != TERN_MID) ? 4'ha : 4'h0;
        end
    end

    // Transmit input clocks come from a divider of the core clock
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            tx_div <= '0;
            LINK.tx_in_clk <= '0;
        end else begin
            tx_div <= (tx_div == 3'(TX_CHAR_CYCLES - 1)) ? 3'h0 : tx_div + 3'h1;
            LINK.tx_in_clk <= {4{tx_div[2]}};
        end
    end

    assign rx_raw = {LINK.rx_clk_c, LINK.rx_clk_t, LINK.rx_parity, LINK.rx_status,
        LINK.rx_data};

    rcs_sync #(
        .W(RW)
    ) u_rx_sync (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .d_i(rx_raw),
        .q_o(rx)
    );

    assign c = rx[55:52];
    assign t = rx[51:48];

    always_comb begin
        for (int ch = 0; ch < 4; ch++) begin
            grp_t[ch] = (src == TERN_MID) ? t[ch] : t[{ch[1], 1'b0}];
            grp_c[ch] = (src == TERN_MID) ? c[ch] : c[{ch[1], 1'b0}];
            grp_t_prev[ch] = (src == TERN_MID) ? t_prev[ch] : t_prev[{ch[1], 1'b0}];
            grp_c_prev[ch] = (src == TERN_MID) ? c_prev[ch] : c_prev[{ch[1], 1'b0}];
        end
    end
    assign edge_seen = (grp_t & ~grp_t_prev)
        | ({4{half}} & grp_c & ~grp_c_prev);

    // Data settles through the same synchroniser, so latch a little after the edge
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            t_prev <= '0;
            c_prev <= '0;
            cap <= '0;
            RX_DATA_O <= '0;
            RX_STATUS_O <= '0;
            RX_PARITY_O <= '0;
            RX_VALID_O <= '0;
        end else begin
            t_prev <= t;
            c_prev <= c;
            for (int ch = 0; ch < 4; ch++) begin
                cap[ch] <= {cap[ch][CAPTURE_DELAY-2:0], edge_seen[ch]};
                RX_VALID_O[ch] <= cap[ch][CAPTURE_DELAY-1];
                if (cap[ch][CAPTURE_DELAY-1]) begin
                    RX_DATA_O[ch*8 +: 8] <= rx[ch*8 +: 8];
                    RX_STATUS_O[ch*3 +: 3] <= rx[32 + ch*3 +: 3];
                    RX_PARITY_O[ch] <= rx[44 + ch];
                end
            end
        end
    end
endmodule // rcs_host
`default_nettype wire

/* File: sim/rcs_link_asserts.sv */
// Checker of the receive pins between the device and host ends.
// Assumes one core clock; sees the resolved pins of the interface.
`timescale 1ns/1ns
`default_nettype none
module rcs_link_asserts
    import rcs_pkg::*;
(
    input wire logic CORE_CLK_I, // Core clock
    input wire logic SYS_RST_I, // Async reset
    input wire logic [1:0] rx_clk_src, // Source code
    input wire logic [1:0] dec_table, // Decoder code
    input wire logic [1:0] parity_ctl, // Parity code
    input wire logic rx_rate, // Half rate
    input wire logic [31:0] rx_data, // Data
    input wire logic [11:0] rx_status, // Status
    input wire logic [3:0] rx_parity_drv, // Parity level
    input wire logic [3:0] rx_parity_oe, // Parity enable
    input wire logic [3:0] rx_clk_t, // True clocks
    input wire logic [3:0] rx_clk_c, // Complement clocks
    input wire logic [3:0] rx_clk_oe // Clock enables
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // Codes cross a synchroniser, so relations wait for a steady code
    sequence src_low; (rx_clk_src == CODE_LOW)[*8]; endsequence
    data_edge_a: assert property ($changed(rx_data[7:0]) && !rx_rate |-> $past(rx_clk_t[0])
        && !$past(rx_clk_t[0], 2)) else $error("data moved without clock rise");
    par_off_a: assert property ((parity_ctl == CODE_LOW)[*8] |-> rx_parity_oe == 4'h0)
        else $error("parity driven while off");
    par_full_a: assert property ((parity_ctl == CODE_HIGH)[*8] ##0 ($past(rx_clk_t[0])
        && !$past(rx_clk_t[0], 2)) |-> ^{rx_data[7:0], rx_status[2:0], rx_parity_drv[0]})
        else $error("parity over data and status wrong");
    par_bypass_a: assert property ((parity_ctl == CODE_MID && dec_table == CODE_LOW)[*8] ##0
        ($past(rx_clk_t[0]) && !$past(rx_clk_t[0], 2)) |->
        ^{rx_data[7:0], rx_status[1:0], rx_parity_drv[0]}) else $error("bypass parity wrong");
    bd_idle_a: assert property (src_low |-> rx_clk_oe[1] == 1'b0 && rx_clk_oe[3] == 1'b0)
        else $error("B or D clock driven");
    ref_skew_a: assert property (src_low |-> rx_clk_t[2] == $past(rx_clk_t[0]))
        else $error("clock C not a delayed A");
    // A source switch may hand over a clock already part way through its high time
    high_time_a: assert property ($rose(rx_clk_t[0]) && !rx_rate && $stable(rx_clk_oe) |->
        rx_clk_t[0][*4] ##1
        !rx_clk_t[0]) else $error("clock high time wrong");
    compl_a: assert property (rx_clk_oe[0] && !rx_rate |-> rx_clk_c[0] != rx_clk_t[0])
        else $error("clocks not complementary");
    cover property ($rose(rx_clk_t[2]) && rx_clk_src == CODE_HIGH);
    cover property (src_low ##1 $rose(rx_clk_t[0]));
    cover property (rx_parity_oe[0] && parity_ctl == CODE_HIGH);
endmodule // rcs_link_asserts
`default_nettype wire

/* File: sim/tb.sv */
// Testbench joining device and host ends through one interface.
// Assumes the package constants; stimulus at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import rcs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rate = 1'b0, refr = 1'b0, prst_n = 1'b0, multi = 1'b0;
    logic [3:0] rec = 4'h0, comma = 4'h0, rxm = 4'h5, txm = 4'h5, hvalid, hpar, rxm_o, txm_o;
    logic [39:0] raw = '0;
    logic [31:0] dbyte = '0, hdata;
    logic [11:0] dstat = '0, hstat, phase;
    logic [1:0] src = CODE_MID, fch = CODE_MID, dec = CODE_LOW, par = CODE_LOW, msel = 2'h0;
    logic dec_en, dec_alt, f_comma, f_k285, f_test, refr_o;
    int fail_count = 0, cmp_count = 0;
    rcs_if rcs_if_i ();
    rcs_device rcs_device_i (.CORE_CLK_I(clk), .SYS_RST_I(rst), .LINK(rcs_if_i), .REC_CHAR_I(rec),
        .RAW_CHAR_I(raw), .DEC_BYTE_I(dbyte), .DEC_STATUS_I(dstat), .COMMA_I(comma),
        .DEC_ENABLE_O(dec_en), .DEC_ALT_TABLE_O(dec_alt), .FRAME_COMMA_O(f_comma),
        .FRAME_K285_O(f_k285), .FRAME_TEST_O(f_test), .REFRAME_O(refr_o), .RX_MODE_O(rxm_o),
        .TX_MODE_O(txm_o), .TX_PHASE_O(phase), .RECONFIG_O());
    rcs_host rcs_host_i (.CORE_CLK_I(clk), .SYS_RST_I(rst), .LINK(rcs_if_i), .RX_CLK_SRC_I(src),
        .RX_MODE_I(rxm), .TX_MODE_I(txm), .FRAME_CHAR_I(fch), .DEC_TABLE_I(dec),
        .PARITY_CTL_I(par), .RX_RATE_I(rate), .REFRAME_I(refr), .TX_PHASE_RST_N_I(prst_n),
        .MULTI_DEVICE_I(multi), .MASTER_SEL_I(msel), .RX_DATA_O(hdata), .RX_STATUS_O(hstat),
        .RX_PARITY_O(hpar), .RX_VALID_O(hvalid));
    rcs_link_asserts rcs_link_asserts_i (.CORE_CLK_I(clk), .SYS_RST_I(rst),
        .rx_clk_src(rcs_if_i.rx_clk_src), .dec_table(rcs_if_i.dec_table),
        .parity_ctl(rcs_if_i.parity_ctl), .rx_rate(rcs_if_i.rx_rate), .rx_data(rcs_if_i.rx_data),
        .rx_status(rcs_if_i.rx_status), .rx_parity_drv(rcs_if_i.rx_parity_drv),
        .rx_parity_oe(rcs_if_i.rx_parity_oe), .rx_clk_t(rcs_if_i.rx_clk_t),
        .rx_clk_c(rcs_if_i.rx_clk_c), .rx_clk_oe(rcs_if_i.rx_clk_oe));
    initial forever #20 clk = ~clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Waits out synchroniser and the settling hold after a select change
    task automatic setup(input logic [1:0] s, input logic [1:0] d, input logic [1:0] p);
        @(negedge clk);
        src = s;
        dec = d;
        par = p;
        repeat (40) @(negedge clk);
    endtask
    task automatic send(input int ch, input logic [9:0] r, input logic [3:0] m, output logic got);
        @(negedge clk);
        raw[ch*10 +: 10] = r;
        rec[ch] = 1'b1;
        @(negedge clk);
        rec[ch] = 1'b0;
        got = 1'b0;
        for (int i = 0; i < 30 && !got; i++) begin
            @(negedge clk);
            got = (hvalid & m) != 4'h0;
        end
        repeat (8) @(negedge clk);
    endtask
    task automatic t_bypass();
        logic got;
        setup(CODE_MID, CODE_LOW, CODE_HIGH);
        comma = 4'h1;
        send(0, 10'h2a5, 4'h1, got);
        check("latch a", got, 1'b1);
        check("data a", hdata[7:0], 8'ha9);
        check("status a", hstat[2:0], 3'h5);
        check("parity a", hpar[0], 1'b1);
        check("decoder", {dec_en, dec_alt}, 2'h0);
    endtask
    task automatic t_decode();
        logic got;
        rate = 1'b1;
        setup(CODE_MID, CODE_MID, CODE_MID);
        dbyte[15:8] = 8'h3c;
        dstat[5:3] = 3'h6;
        send(1, 10'h000, 4'h2, got);
        check("data b", hdata[15:8], 8'h3c);
        check("status b", hstat[5:3], 3'h6);
        check("parity b", hpar[1], 1'b1);
        check("decoder", {dec_en, dec_alt}, 2'h2);
        setup(CODE_MID, CODE_HIGH, CODE_LOW);
        check("decoder", {dec_en, dec_alt}, 2'h3);
        send(1, 10'h000, 4'h2, got);
        check("parity off", {hpar[1], rcs_if_i.rx_parity_oe}, 5'h00);
    endtask
    task automatic t_modes();
        logic [1:0] c [3] = '{CODE_LOW, CODE_FLOAT, CODE_HIGH};
        for (int i = 0; i < 9; i++) begin
            @(negedge clk);
            rxm = {c[i / 3], c[i % 3]};
            txm = {c[i % 3], c[i / 3]};
            fch = c[i % 3];
            refr = i[0];
            repeat (10) @(negedge clk);
            check("rx mode", rxm_o, i[3:0]);
            check("tx mode", txm_o, (i % 3) * 3 + i / 3);
            check("framing", {f_test, f_comma, f_k285}, 3'h4 >> (i % 3));
            check("reframe", refr_o, i[0]);
        end
    endtask
    task automatic t_master();
        logic got;
        @(negedge clk);
        rxm = {CODE_HIGH, CODE_HIGH};
        setup(CODE_HIGH, CODE_MID, CODE_MID);
        for (int ch = 0; ch < 4; ch++) begin
            msel = {ch[0], ch[1]};
            repeat (8) @(negedge clk);
            send(ch, 10'h155, 4'h5, got);
            check("master clock", got, 1'b1);
        end
        rxm = {CODE_MID, CODE_LOW};
        msel = 2'h1;
        setup(CODE_HIGH, CODE_MID, CODE_MID);
        send(0, 10'h0f0, 4'h1, got);
        check("unselected a", got, 1'b0);
        send(1, 10'h0f0, 4'h1, got);
        check("selected b", got, 1'b1);
    endtask
    task automatic t_ref();
        logic [11:0] held;
        logic got = 1'b0;
        @(negedge clk);
        prst_n = 1'b1;
        multi = 1'b1;
        setup(CODE_MID, CODE_MID, CODE_HIGH);
        held = phase;
        check("bd idle", {rcs_if_i.rx_clk_oe[3], rcs_if_i.rx_clk_oe[1]}, 2'h0);
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            got |= hvalid[2];
        end
        check("ref latch", got, 1'b1);
        check("phase held", phase, held);
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #160;
        rst = 1'b0;
        repeat (30) @(negedge clk);
        t_bypass();
        t_decode();
        t_modes();
        t_master();
        t_ref();
        tally_and_finish();
    end
    // At most about 800 cycles are needed; this allows over ten times that
    initial begin
        #400000;
        fail_count++;
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
